// File: core/tcc_pkg.sv
package tcc_pkg;
  // register byte addresses on the 8-bit port
  localparam logic [3:0] ADDR_CTRL_A     = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B     = 4'h1;
  localparam logic [3:0] ADDR_CTRL_C     = 4'h2;
  localparam logic [3:0] ADDR_CMP_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h4;
  localparam logic [3:0] ADDR_FLAGS      = 4'h5;
  localparam logic [3:0] ADDR_CAP_LO     = 4'h6;
  localparam logic [3:0] ADDR_CAP_HI     = 4'h7;
  localparam logic [3:0] ADDR_CMPA_LO    = 4'h8;
  localparam logic [3:0] ADDR_CMPA_HI    = 4'h9;
  localparam logic [3:0] ADDR_CMPB_LO    = 4'ha;
  localparam logic [3:0] ADDR_CMPB_HI    = 4'hb;
  // field positions
  localparam int COM_A_LSB     = 6;
  localparam int COM_B_LSB     = 4;
  localparam int WGM_LO_LSB    = 0;
  localparam int FILT_EN_BIT   = 7;
  localparam int EDGE_RISE_BIT = 6;
  localparam int WGM_HI_LSB    = 3;
  localparam int FORCE_A_BIT   = 7;
  localparam int FORCE_B_BIT   = 6;
  localparam int CAP_SEL_BIT   = 2;
  localparam int CMP_OUT_BIT   = 5;
  localparam int CAP_BIT       = 5;
  localparam int CMPB_BIT      = 2;
  localparam int CMPA_BIT      = 1;
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0]  RST_WGM  = 4'h0;
  localparam logic [1:0]  RST_COM  = 2'h0;
  // compare output actions
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;
  // waveform modes of note
  localparam logic [3:0] WGM_NORMAL  = 4'h0;
  localparam logic [3:0] WGM_CTC_CMP = 4'h4;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_CMP = 4'h9;
  localparam logic [3:0] WGM_PC_CAP  = 4'ha;
  localparam logic [3:0] WGM_CTC_CAP = 4'hc;
  localparam logic [3:0] WGM_RSVD    = 4'hd;
  localparam logic [3:0] WGM_FAST_CAP = 4'he;
  localparam int FILT_DEPTH = 4;

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == WGM_NORMAL || m == WGM_CTC_CMP || m == WGM_CTC_CAP || m == WGM_RSVD);
  endfunction : is_pwm

  function automatic logic cap_top(input logic [3:0] m);
    cap_top = (m == WGM_PFC_CAP || m == WGM_PC_CAP || m == WGM_CTC_CAP || m == WGM_FAST_CAP);
  endfunction : cap_top

  // phase correct modes reload at top, the others at bottom
  function automatic logic load_at_top(input logic [3:0] m);
    load_at_top = (m[3:2] == 2'b00) || (m == WGM_PC_CAP) || (m == 4'hb);
  endfunction : load_at_top
endpackage : tcc_pkg

// File: core/tcc_capture_compare.sv
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - capture source pin, or comparator when selected
// - source switch may capture; software clears flag
// - both sources synchronised, same edge detector
// - filter output changes after four equal samples
// - filter active only when enable bit set
// - filter adds exactly four clock cycles latency
// - filter samples on undivided system clock
// - capture disabled in capture-defines-top modes
// - every new capture overwrites captured value
// - software-driven pin edge also captures
// - 16-bit compare, flag one tick later
// - flag requests irq, cleared by ack/write-one
// - channel A match can define counter top
// - pwm modes double buffer, others write direct
// - cpu reaches buffer in pwm, else active
// - compare changes on writes, high read direct
// - high byte to temp, low write commits
// - force strobe acts like match, no flag
// - counter write blocks matches next tick
// - written-equal top match ignored, counts on
// - output state kept across mode changes
// - output mode bits take effect immediately
// - capture copies counter and sets flag together
// - reset clears compare output states
module tcc_capture_compare
  import tcc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_capture_pin,
  input  wire logic        i_comparator_out,
  input  wire logic [15:0] i_count,
  input  wire logic        i_count_tick,
  input  wire logic        i_count_top,
  input  wire logic        i_count_bottom,
  input  wire logic        i_count_wr,
  input  wire logic        i_ack_capture,
  input  wire logic        i_ack_cmp_a,
  input  wire logic        i_ack_cmp_b,
  output logic             o_irq_capture,
  output logic             o_irq_cmp_a,
  output logic             o_irq_cmp_b,
  output logic             o_match_a,
  output logic             o_match_b,
  output logic      [15:0] o_top_value,
  output logic      [3:0]  o_waveform_mode,
  output logic             o_cmp_state_a,
  output logic             o_cmp_state_b
);

  typedef struct packed {
    logic [1:0]  sync_pin;
    logic [1:0]  sync_cmp;
    logic [3:0]  filt_sh;
    logic        filt;
    logic        trig_q;
    logic        lvl_prev;
    logic [1:0]  com_a;
    logic [1:0]  com_b;
    logic [3:0]  wgm;
    logic        filt_en;
    logic        edge_rise;
    logic        cap_sel;
    logic        ie_cap;
    logic        ie_a;
    logic        ie_b;
    logic        flag_cap;
    logic        flag_a;
    logic        flag_b;
    logic [15:0] capture;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [7:0]  temp;
    logic        blk;
    logic        st_a;
    logic        st_b;
    logic [7:0]  rdata;
  } tcc_state_type;

  tcc_state_type st;
  tcc_state_type next_st;

  function automatic logic com_apply(input logic [1:0] com, input logic cur);
    case (com)
      COM_TOGGLE: com_apply = !cur;
      COM_CLEAR:  com_apply = 1'b0;
      COM_SET:    com_apply = 1'b1;
      default:    com_apply = cur;
    endcase
  endfunction : com_apply

  logic        trig_src;
  logic        lvl;
  logic        cap_evt;
  logic        m_a;
  logic        m_b;
  logic        pwm;
  logic        reload;
  logic        wr_lo_a;
  logic        wr_lo_b;
  logic        force_a;
  logic        force_b;
  logic        clr_wr;
  logic [15:0] word_in;

  always_comb begin
    trig_src = st.cap_sel ? st.sync_cmp[1] : st.sync_pin[1];
    lvl      = st.filt_en ? st.filt : st.trig_q;
    // only the edge of the chosen polarity; source switch counts as a change too
    cap_evt  = (lvl != st.lvl_prev) && (lvl == st.edge_rise)
               && !cap_top(st.wgm);
    pwm      = is_pwm(st.wgm);
    // no early match while blocked, so a written-equal top is passed by
    m_a      = i_count_tick && (i_count == st.cmp_a) && !st.blk;
    m_b      = i_count_tick && (i_count == st.cmp_b) && !st.blk;
    reload   = pwm && i_count_tick
               && (load_at_top(st.wgm) ? i_count_top : i_count_bottom);
    wr_lo_a  = i_wr && (i_addr == ADDR_CMPA_LO);
    wr_lo_b  = i_wr && (i_addr == ADDR_CMPB_LO);
    force_a  = i_wr && (i_addr == ADDR_CTRL_C) && i_wdata[FORCE_A_BIT] && !pwm;
    force_b  = i_wr && (i_addr == ADDR_CTRL_C) && i_wdata[FORCE_B_BIT] && !pwm;
    clr_wr   = i_wr && (i_addr == ADDR_FLAGS);
    word_in  = {st.temp, i_wdata};
  end

  always_comb begin
    next_st = st;
    // first stage feeds only the second stage
    next_st.sync_pin = {st.sync_pin[0], i_capture_pin};
    next_st.sync_cmp = {st.sync_cmp[0], i_comparator_out};
    next_st.trig_q   = trig_src;
    // runs every system clock, prescaler plays no part
    next_st.filt_sh  = {st.filt_sh[2:0], trig_src};
    if (&st.filt_sh || ~|st.filt_sh) begin
      next_st.filt = st.filt_sh[FILT_DEPTH-1];
    end
    next_st.lvl_prev = lvl;
    if (cap_evt) begin
      next_st.capture = i_count;
    end
    // write-through to active register in non-pwm, buffer otherwise
    if (reload) begin
      next_st.cmp_a = st.buf_a;
      next_st.cmp_b = st.buf_b;
    end
    if (wr_lo_a) begin
      next_st.buf_a = word_in;
      if (!pwm) begin
        next_st.cmp_a = word_in;
      end
    end
    if (wr_lo_b) begin
      next_st.buf_b = word_in;
      if (!pwm) begin
        next_st.cmp_b = word_in;
      end
    end
    if (i_count_wr) begin
      next_st.blk = 1'b1;
    end else if (i_count_tick) begin
      next_st.blk = 1'b0;
    end
    // set wins over ack or write-one clear
    next_st.flag_cap = (st.flag_cap && !i_ack_capture && !(clr_wr && i_wdata[CAP_BIT]))
                       || cap_evt;
    next_st.flag_a   = (st.flag_a && !i_ack_cmp_a && !(clr_wr && i_wdata[CMPA_BIT]))
                       || m_a;
    next_st.flag_b   = (st.flag_b && !i_ack_cmp_b && !(clr_wr && i_wdata[CMPB_BIT]))
                       || m_b;
    // pwm waveform shaping lives outside; state held there, never reset by mode
    if ((m_a && !pwm) || force_a) begin
      next_st.st_a = com_apply(st.com_a, st.st_a);
    end
    if ((m_b && !pwm) || force_b) begin
      next_st.st_b = com_apply(st.com_b, st.st_b);
    end
    next_st.rdata = 8'h00;
    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL_A: begin
          next_st.com_a    = i_wdata[COM_A_LSB +: 2];
          next_st.com_b    = i_wdata[COM_B_LSB +: 2];
          next_st.wgm[1:0] = i_wdata[WGM_LO_LSB +: 2];
        end
        ADDR_CTRL_B: begin
          next_st.filt_en   = i_wdata[FILT_EN_BIT];
          next_st.edge_rise = i_wdata[EDGE_RISE_BIT];
          next_st.wgm[3:2]  = i_wdata[WGM_HI_LSB +: 2];
        end
        ADDR_CMP_STATUS: next_st.cap_sel = i_wdata[CAP_SEL_BIT];
        ADDR_IRQ_MASK: begin
          next_st.ie_cap = i_wdata[CAP_BIT];
          next_st.ie_a   = i_wdata[CMPA_BIT];
          next_st.ie_b   = i_wdata[CMPB_BIT];
        end
        ADDR_CAP_LO: begin
          if (cap_top(st.wgm) && !cap_evt) begin
            next_st.capture = word_in;
          end
        end
        ADDR_CAP_HI, ADDR_CMPA_HI, ADDR_CMPB_HI: next_st.temp = i_wdata;
        default: begin
        end
      endcase
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CTRL_A: begin
          next_st.rdata[COM_A_LSB +: 2]  = st.com_a;
          next_st.rdata[COM_B_LSB +: 2]  = st.com_b;
          next_st.rdata[WGM_LO_LSB +: 2] = st.wgm[1:0];
        end
        ADDR_CTRL_B: begin
          next_st.rdata[FILT_EN_BIT]      = st.filt_en;
          next_st.rdata[EDGE_RISE_BIT]    = st.edge_rise;
          next_st.rdata[WGM_HI_LSB +: 2]  = st.wgm[3:2];
        end
        ADDR_CMP_STATUS: begin
          next_st.rdata[CAP_SEL_BIT] = st.cap_sel;
          next_st.rdata[CMP_OUT_BIT] = st.sync_cmp[1];
        end
        ADDR_IRQ_MASK: begin
          next_st.rdata[CAP_BIT]  = st.ie_cap;
          next_st.rdata[CMPA_BIT] = st.ie_a;
          next_st.rdata[CMPB_BIT] = st.ie_b;
        end
        ADDR_FLAGS: begin
          next_st.rdata[CAP_BIT]  = st.flag_cap;
          next_st.rdata[CMPA_BIT] = st.flag_a;
          next_st.rdata[CMPB_BIT] = st.flag_b;
        end
        ADDR_CAP_LO: begin
          next_st.rdata = st.capture[7:0];
          next_st.temp  = st.capture[15:8];
        end
        ADDR_CAP_HI:  next_st.rdata = st.temp;
        // compare high bytes never go through temp
        ADDR_CMPA_LO: next_st.rdata = pwm ? st.buf_a[7:0] : st.cmp_a[7:0];
        ADDR_CMPA_HI: next_st.rdata = pwm ? st.buf_a[15:8] : st.cmp_a[15:8];
        ADDR_CMPB_LO: next_st.rdata = pwm ? st.buf_b[7:0] : st.cmp_b[7:0];
        ADDR_CMPB_HI: next_st.rdata = pwm ? st.buf_b[15:8] : st.cmp_b[15:8];
        default:      next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st           <= '0;
      st.wgm       <= RST_WGM;
      st.com_a     <= RST_COM;
      st.com_b     <= RST_COM;
      st.capture   <= RST_WORD;
      st.cmp_a     <= RST_WORD;
      st.cmp_b     <= RST_WORD;
      st.buf_a     <= RST_WORD;
      st.buf_b     <= RST_WORD;
      st.temp      <= RST_BYTE;
      st.rdata     <= RST_BYTE;
      st.st_a      <= 1'b0;
      st.st_b      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata         = st.rdata;
  assign o_irq_capture   = st.flag_cap && st.ie_cap;
  assign o_irq_cmp_a     = st.flag_a && st.ie_a;
  assign o_irq_cmp_b     = st.flag_b && st.ie_b;
  assign o_match_a       = m_a;
  assign o_match_b       = m_b;
  assign o_top_value     = cap_top(st.wgm) ? st.capture : st.cmp_a;
  assign o_waveform_mode = st.wgm;
  assign o_cmp_state_a   = st.st_a;
  assign o_cmp_state_b   = st.st_b;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence filt_stable_s;
    (st.filt_en && !st.cap_sel && $stable(i_capture_pin))[*8];
  endsequence

  cap_store_a: assert property (cap_evt |=> st.capture == $past(i_count) && st.flag_cap)
    else $error("capture did not store counter with flag");
  cap_blocked_a: assert property (cap_top(st.wgm) |-> !cap_evt)
    else $error("capture fired in capture-top mode");
  filt_change_a: assert property ($changed(st.filt) |-> $past(&st.filt_sh || ~|st.filt_sh))
    else $error("filter moved without four equal samples");
  filt_settle_a: assert property (filt_stable_s |-> st.filt == st.sync_pin[1])
    else $error("filter did not settle on steady input");
  flag_late_a: assert property (m_a |=> st.flag_a)
    else $error("compare flag not set after match");
  wr_block_a: assert property (i_count_wr ##1 (i_count_tick && !i_count_wr) |-> !o_match_a && !o_match_b)
    else $error("match seen right after counter write");
  direct_wr_a: assert property (wr_lo_a && !pwm |=> st.cmp_a == {$past(st.temp), $past(i_wdata)})
    else $error("non-pwm low write did not reach compare");
  buffered_wr_a: assert property (wr_lo_a && pwm && !reload |=> $stable(st.cmp_a))
    else $error("pwm write reached active compare");
  force_nf_a: assert property (force_a && !m_a && !st.flag_a |=> !st.flag_a)
    else $error("force strobe set compare flag");
  force_tgl_a: assert property (force_a && st.com_a == COM_TOGGLE |=> st.st_a != $past(st.st_a))
    else $error("force toggle did not toggle");
  ack_clear_a: assert property (st.flag_a && i_ack_cmp_a && !m_a |=> !st.flag_a)
    else $error("compare flag survived its acknowledge");

endmodule : tcc_capture_compare

// File: dv/tcc_counter_model.sv
`timescale 1ns/1ps
// stands in for the counter unit beside the block: one tick per clock while running
module tcc_counter_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_run,
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_val,
  output logic      [15:0] o_count,
  output logic             o_tick,
  output logic             o_top,
  output logic             o_bottom,
  output logic             o_count_wr
);
  assign o_tick = i_run;
  // fixed top only; a written-equal variable top is never produced here
  assign o_top = i_run & (o_count == 16'hffff);
  assign o_bottom = i_run & (o_count == 16'h0000);
  // a cpu write wins over counting
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_count <= 16'h0000;
      o_count_wr <= 1'b0;
    end else begin
      o_count_wr <= i_load;
      if (i_load) begin
        o_count <= i_load_val;
      end else if (i_run) begin
        o_count <= o_count + 16'h0001;
      end
    end
  end
endmodule : tcc_counter_model

// File: dv/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  import tcc_pkg::*;
  logic        i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, rd_d = 0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00, o_rdata;
  logic        i_capture_pin = 0, i_comparator_out = 0, run = 0, load = 0;
  logic        i_ack_capture = 0, i_ack_cmp_a = 0, i_ack_cmp_b = 0;
  logic [15:0] load_val = 16'h0000, i_count, o_top_value, v, w;
  logic        i_count_tick, i_count_top, i_count_bottom, i_count_wr;
  logic        o_irq_capture, o_irq_cmp_a, o_irq_cmp_b, o_match_a, o_match_b;
  logic        o_cmp_state_a, o_cmp_state_b;
  logic [3:0]  o_waveform_mode;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_v;
  int          n_fail = 0, comparisons = 0, n0, n1;

  always #12.5 i_clk = ~i_clk;

  tcc_counter_model tcc_counter_model_i (.i_clk, .i_rst_n, .i_run(run), .i_load(load),
    .i_load_val(load_val), .o_count(i_count), .o_tick(i_count_tick), .o_top(i_count_top),
    .o_bottom(i_count_bottom), .o_count_wr(i_count_wr));
  tcc_capture_compare tcc_capture_compare_i (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_capture_pin, .i_comparator_out, .i_count, .i_count_tick,
    .i_count_top, .i_count_bottom, .i_count_wr, .i_ack_capture, .i_ack_cmp_a,
    .i_ack_cmp_b, .o_irq_capture, .o_irq_cmp_a, .o_irq_cmp_b, .o_match_a, .o_match_b,
    .o_top_value, .o_waveform_mode, .o_cmp_state_a, .o_cmp_state_b);

  // read data stand only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (rd_d) begin
      // pop once; the macro names its expected value twice
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, o_rdata)
    end
    rd_d <= i_rd;
  end

  task automatic close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // an idle cycle after each strobe keeps a strobe from being driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask : rd

  task automatic ld(input logic [15:0] val);
    load_val <= val;
    load <= 1'b1;
    @(posedge i_clk);
    load <= 1'b0;
    @(posedge i_clk);
  endtask : ld

  // toggles one trigger source, counts cycles until the capture irq shows (30 = none)
  task automatic hit(input logic cmp, output int n);
    if (cmp) i_comparator_out <= ~i_comparator_out;
    else i_capture_pin <= ~i_capture_pin;
    n = 0;
    while (n < 30 && o_irq_capture !== 1'b1) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
  endtask : hit

  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    close_out();
  end

  initial begin
    void'($urandom(18));
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    `CHK("state_a", 1'b0, o_cmp_state_a)
    rd(ADDR_CTRL_A, 8'h00);
    rd(ADDR_CAP_HI, 8'h00);
    rd(4'hf, 8'h00);
    v = 16'h1000 + 16'($urandom_range(16'h0fff));
    wr(ADDR_CMPA_HI, v[15:8]);
    `CHK("top_hi_only", 16'h0000, o_top_value)
    wr(ADDR_CMPA_LO, v[7:0]);
    `CHK("top_direct", v, o_top_value)
    rd(ADDR_CMPA_HI, v[15:8]);
    rd(ADDR_CMPA_LO, v[7:0]);
    // match, flag one tick later, irq, cleared by ack
    wr(ADDR_IRQ_MASK, 8'h02);
    ld(v - 16'h0003);
    run <= 1'b1;
    n0 = 0;
    while (n0 < 20 && o_irq_cmp_a !== 1'b1) begin
      @(posedge i_clk);
      #1;
      n0++;
    end
    `CHK("count_at_flag", v + 16'h0001, i_count)
    @(posedge i_clk);
    run <= 1'b0;
    i_ack_cmp_a <= 1'b1;
    @(posedge i_clk);
    i_ack_cmp_a <= 1'b0;
    @(posedge i_clk);
    `CHK("irq_after_ack", 1'b0, o_irq_cmp_a)
    // masked match still flags; write-one clears
    wr(ADDR_IRQ_MASK, 8'h00);
    ld(v - 16'h0001);
    run <= 1'b1;
    repeat (3) @(posedge i_clk);
    run <= 1'b0;
    `CHK("irq_masked", 1'b0, o_irq_cmp_a)
    rd(ADDR_FLAGS, 8'h02);
    wr(ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS, 8'h00);
    // counter write blocks the match of the next tick
    ld(v);
    run <= 1'b1;
    @(posedge i_clk);
    run <= 1'b0;
    repeat (2) @(posedge i_clk);
    rd(ADDR_FLAGS, 8'h00);
    // force strobes, output mode taking effect at once, no flag
    wr(ADDR_CTRL_A, {COM_TOGGLE, COM_TOGGLE, 4'h0});
    wr(ADDR_CTRL_C, 8'hc0);
    `CHK("force_toggle", 1'b1, o_cmp_state_a)
    `CHK("force_toggle_b", 1'b1, o_cmp_state_b)
    wr(ADDR_CTRL_A, {COM_CLEAR, 6'h00});
    wr(ADDR_CTRL_C, 8'h80);
    `CHK("force_clear", 1'b0, o_cmp_state_a)
    wr(ADDR_CTRL_A, {COM_SET, 6'h00});
    wr(ADDR_CTRL_C, 8'h80);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL_A, 8'hc1);
    `CHK("state_kept", 1'b1, o_cmp_state_a)
    `CHK("mode", 4'h1, o_waveform_mode)
    // mode 1: buffered write reaches the active value only at top
    w = v ^ 16'h0a5a;
    wr(ADDR_CMPA_HI, w[15:8]);
    wr(ADDR_CMPA_LO, w[7:0]);
    `CHK("top_buffered", v, o_top_value)
    rd(ADDR_CMPA_LO, w[7:0]);
    ld(16'hfffe);
    run <= 1'b1;
    repeat (3) @(posedge i_clk);
    run <= 1'b0;
    `CHK("top_at_top", w, o_top_value)
    // capture: rising edge, plain then filtered
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h20);
    wr(ADDR_CTRL_B, 8'h40);
    ld(v);
    wr(ADDR_FLAGS, 8'h20);
    hit(1'b0, n0);
    rd(ADDR_CAP_LO, v[7:0]);
    rd(ADDR_CAP_HI, v[15:8]);
    wr(ADDR_FLAGS, 8'h20);
    hit(1'b0, n1);
    `CHK("fall_ignored", 30, n1)
    wr(ADDR_CTRL_B, 8'hc0);
    ld(w);
    wr(ADDR_FLAGS, 8'h20);
    hit(1'b0, n1);
    `CHK("filter_delay", n0 + 4, n1)
    // a glitch shorter than four samples never reaches the edge detector
    wr(ADDR_FLAGS, 8'h20);
    i_capture_pin <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_capture_pin <= 1'b1;
    repeat (12) @(posedge i_clk);
    `CHK("glitch", 1'b0, o_irq_capture)
    ld(~v);
    hit(1'b0, n1);
    hit(1'b0, n1);
    rd(ADDR_CAP_LO, ~v[7:0]);
    rd(ADDR_CAP_HI, ~v[15:8]);
    // comparator as source; flag cleared after the switch
    wr(ADDR_CMP_STATUS, 8'h04);
    wr(ADDR_FLAGS, 8'h20);
    hit(1'b1, n1);
    `CHK("cmp_source", 1'b1, n1 < 30)
    // capture-defines-top mode: no capture
    wr(ADDR_CTRL_B, 8'h58);
    wr(ADDR_FLAGS, 8'h20);
    hit(1'b1, n1);
    hit(1'b1, n1);
    `CHK("cap_top_mode", 30, n1)
    close_out();
  end
endmodule : testbench
